/* logic/radio_status_pkg.sv */
// radio status register bank: offsets, field positions, state codes
// shared by the bank top and its packet_flags helper module
package radio_status_pkg;
  localparam logic [5:0] OFS_RADIO_FSM_STATE     = 6'h35;
  localparam logic [5:0] OFS_WAKE_TIMER_HIGH     = 6'h36;
  localparam logic [5:0] OFS_WAKE_TIMER_LOW      = 6'h37;
  localparam logic [5:0] OFS_PACKET_PIN_STATUS   = 6'h38;
  localparam logic [5:0] OFS_PLL_CAL_SETTING     = 6'h39;
  localparam logic [5:0] OFS_TX_FIFO_LEVEL       = 6'h3a;
  localparam logic [5:0] OFS_RX_FIFO_LEVEL       = 6'h3b;
  localparam logic [5:0] OFS_RC_CAL_RESULT_ONE   = 6'h3c;
  localparam logic [5:0] OFS_RC_CAL_RESULT_ZERO  = 6'h3d;

  localparam int BIT_CRC_OK        = 7;
  localparam int BIT_CARRIER_SENSE = 6;
  localparam int BIT_PQ_MET        = 5;
  localparam int BIT_CHANNEL_CLEAR = 4;
  localparam int BIT_FRAME_START   = 3;
  localparam int BIT_PIN_TWO       = 2;
  localparam int BIT_PIN_ZERO      = 0;
  localparam int BIT_FIFO_FLAG     = 7;

  localparam logic [4:0] ST_IDLE     = 5'h01;
  localparam logic [4:0] ST_RX       = 5'h0d;
  localparam logic [4:0] ST_RX_END   = 5'h0e;
  localparam logic [4:0] ST_RX_RST   = 5'h0f;
  localparam logic [4:0] ST_RX_OVFL  = 5'h11;
  localparam logic [4:0] ST_TX       = 5'h13;
  localparam logic [4:0] ST_TX_END   = 5'h14;

  localparam logic [7:0] RST_BYTE    = 8'h00;
  localparam logic [4:0] RST_STATE   = 5'h00;
endpackage

/* logic/pin_sync.sv */
// two-flop synchroniser for a vector of levels from outside the clock
// assumes clk_sys domain, synchronous active-high reset
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_sys,
  input  wire logic         srst,
  input  wire logic [W-1:0] pinAsync,
  output logic      [W-1:0] pinSync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_t;
  sync_t s_q;
  sync_t s_d;

  always_comb begin
    s_d.meta   = pinAsync;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pinSync = s_q.stable;
endmodule

/* logic/packet_flags.sv */
// packet flags: sticky crc match, preamble quality met and frame start,
// per-cycle carrier sense; driven by same-clock radio core events
`timescale 1ns/100ps
module packet_flags (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic [4:0] radioState,
  input  wire logic       crcDone,
  input  wire logic       crcMatch,
  input  wire logic       carrierSense,
  input  wire logic [7:0] preambleQualityLevel,
  input  wire logic [7:0] preambleQualityThreshold,
  input  wire logic       syncFound,
  input  wire logic       packetEnd,
  input  wire logic       packetDiscard,
  output logic            crcOk,
  output logic            carrierFlag,
  output logic            pqMet,
  output logic            frameStart
);
  typedef struct packed {
    logic [4:0] prevState;
    logic       crcOk;
    logic       carrier;
    logic       pqMet;
    logic       frameStart;
  } flags_t;
  flags_t f_q;
  flags_t f_d;

  function automatic logic isRx(input logic [4:0] s);
    isRx = (s == radio_status_pkg::ST_RX) ||
           (s == radio_status_pkg::ST_RX_END) ||
           (s == radio_status_pkg::ST_RX_RST);
  endfunction

  logic rxEnter;
  logic rxRestart;
  logic inTx;

  always_comb begin
    rxEnter   = isRx(radioState) && !isRx(f_q.prevState);
    rxRestart = radioState == radio_status_pkg::ST_RX_RST;
    inTx      = (radioState == radio_status_pkg::ST_TX) ||
                (radioState == radio_status_pkg::ST_TX_END);
    f_d = f_q;
    f_d.prevState = radioState;
    if (crcDone) begin
      f_d.crcOk = crcMatch;
    end else if (rxEnter || rxRestart) begin
      f_d.crcOk = 1'b0;
    end
    f_d.carrier = carrierSense && (radioState != radio_status_pkg::ST_IDLE);
    if (preambleQualityLevel < preambleQualityThreshold) begin
      f_d.pqMet = 1'b0;
    end else if (isRx(radioState)) begin
      // only receive sets it, so a set flag holds outside receive
      f_d.pqMet = 1'b1;
    end
    if (inTx) begin
      f_d.frameStart = 1'b0;
    end else if (syncFound && isRx(radioState)) begin
      // a new sync word wins over a clear in the same cycle
      f_d.frameStart = 1'b1;
    end else if (packetEnd || packetDiscard ||
                 radioState == radio_status_pkg::ST_RX_OVFL) begin
      f_d.frameStart = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      f_q <= '0;
    end else begin
      f_q <= f_d;
    end
  end

  assign crcOk       = f_q.crcOk;
  assign carrierFlag = f_q.carrier;
  assign pqMet       = f_q.pqMet;
  assign frameStart  = f_q.frameStart;
endmodule

/* logic/radio_status_register_bank.sv */
// read-only status register bank of the radio, offsets 0x35..0x3d
// assumes a serial register front end issuing one-cycle read/write
// strobes with a 6-bit address on clk_sys; status sources on clk_sys
// except the two output pins, which are synchronised here
`timescale 1ns/100ps
//
// Contract
// - crc match in bit 7, cleared on entering or restarting receive
// - carrier sense in bit 6, cleared on entering idle
// - preamble quality bit set only in receive states 0x0D..0x0F, held outside receive
// - preamble quality bit cleared when level drops below threshold
// - frame start bit set on sync word, cleared at packet end
// - frame start also cleared on filter discard or receive overflow
// - frame start reads zero while transmitting
// - bit 2 shows output pin two level, not inverted
// - bit 0 shows output pin zero level, not inverted
// - wake timer split over high and low byte registers
// - tx level: count in 6:0, underrun flag in bit 7
// - rx level: count in 6:0, overrun flag in bit 7
// - pll calibration setting readable as 8-bit test register
// - rc calibration results in bits 6:0, bit 7 zero
module radio_status_register_bank (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       regRead,
  input  wire logic       regWrite,
  input  wire logic [5:0] regAddr,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  output logic            regRvalid,
  output logic            regHit,
  input  wire logic [4:0] radioState,
  input  wire logic [15:0] wakeTimer,
  input  wire logic       crcDone,
  input  wire logic       crcMatch,
  input  wire logic       carrierSense,
  input  wire logic [7:0] preambleQualityLevel,
  input  wire logic [7:0] preambleQualityThreshold,
  input  wire logic       channelClear,
  input  wire logic       syncFound,
  input  wire logic       packetEnd,
  input  wire logic       packetDiscard,
  input  wire logic       pinTwoLevel,
  input  wire logic       pinZeroLevel,
  input  wire logic [7:0] pllCalSetting,
  input  wire logic [6:0] transmitByteCount,
  input  wire logic       transmitBufferUnderrun,
  input  wire logic [6:0] receiveByteCount,
  input  wire logic       receiveBufferOverrun,
  input  wire logic [6:0] rcCalResultOne,
  input  wire logic [6:0] rcCalResultZero
);
  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
    logic       hit;
  } bank_t;
  bank_t b_q;
  bank_t b_d;

  logic [1:0] pinSync;
  logic crcOk;
  logic carrierFlag;
  logic pqMet;
  logic frameStart;
  logic [7:0] packetStatus;

  // levels are the raw pin values before any output inversion
  pin_sync #(.W(2)) u_pin_sync (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .pinAsync ({pinTwoLevel, pinZeroLevel}),
    .pinSync  (pinSync)
  );

  packet_flags u_packet_flags (
    .clk_sys                  (clk_sys),
    .srst                     (srst),
    .radioState               (radioState),
    .crcDone                  (crcDone),
    .crcMatch                 (crcMatch),
    .carrierSense             (carrierSense),
    .preambleQualityLevel     (preambleQualityLevel),
    .preambleQualityThreshold (preambleQualityThreshold),
    .syncFound                (syncFound),
    .packetEnd                (packetEnd),
    .packetDiscard            (packetDiscard),
    .crcOk                    (crcOk),
    .carrierFlag              (carrierFlag),
    .pqMet                    (pqMet),
    .frameStart               (frameStart)
  );

  always_comb begin
    packetStatus = 8'h00;
    packetStatus[radio_status_pkg::BIT_CRC_OK]        = crcOk;
    packetStatus[radio_status_pkg::BIT_CARRIER_SENSE] = carrierFlag;
    packetStatus[radio_status_pkg::BIT_PQ_MET]        = pqMet;
    packetStatus[radio_status_pkg::BIT_CHANNEL_CLEAR] = channelClear;
    // the flag register lags the state by a cycle, so mask it live
    packetStatus[radio_status_pkg::BIT_FRAME_START]   = frameStart &&
      radioState != radio_status_pkg::ST_TX &&
      radioState != radio_status_pkg::ST_TX_END;
    packetStatus[radio_status_pkg::BIT_PIN_TWO]       = pinSync[1];
    packetStatus[radio_status_pkg::BIT_PIN_ZERO]      = pinSync[0];
  end

  // writes carry no effect; regWrite and regWdata are accepted and dropped
  always_comb begin
    b_d = b_q;
    b_d.rvalid = regRead;
    b_d.hit    = 1'b0;
    if (regRead) begin
      b_d.hit   = 1'b1;
      b_d.rdata = radio_status_pkg::RST_BYTE;
      unique case (regAddr)
        radio_status_pkg::OFS_RADIO_FSM_STATE: begin
          b_d.rdata = {3'h0, radioState};
        end
        radio_status_pkg::OFS_WAKE_TIMER_HIGH: begin
          b_d.rdata = wakeTimer[15:8];
        end
        radio_status_pkg::OFS_WAKE_TIMER_LOW: begin
          b_d.rdata = wakeTimer[7:0];
        end
        radio_status_pkg::OFS_PACKET_PIN_STATUS: begin
          b_d.rdata = packetStatus;
        end
        radio_status_pkg::OFS_PLL_CAL_SETTING: begin
          b_d.rdata = pllCalSetting;
        end
        radio_status_pkg::OFS_TX_FIFO_LEVEL: begin
          b_d.rdata = {transmitBufferUnderrun, transmitByteCount};
        end
        radio_status_pkg::OFS_RX_FIFO_LEVEL: begin
          b_d.rdata = {receiveBufferOverrun, receiveByteCount};
        end
        radio_status_pkg::OFS_RC_CAL_RESULT_ONE: begin
          b_d.rdata = {1'b0, rcCalResultOne};
        end
        radio_status_pkg::OFS_RC_CAL_RESULT_ZERO: begin
          b_d.rdata = {1'b0, rcCalResultZero};
        end
        default: begin
          b_d.hit = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      b_q <= '0;
    end else begin
      b_q <= b_d;
    end
  end

  assign regRdata  = b_q.rdata;
  assign regRvalid = b_q.rvalid;
  assign regHit    = b_q.hit;
endmodule

/* tb/radio_status_props.sv */
// checker for the radio status bank, sees a subset of the top ports
// bound from the bench top; one clock, synchronous active-high reset
`timescale 1ns/100ps
module radio_status_props (
  input wire logic        clk_sys, srst, regRead, regWrite, regRvalid,
  input wire logic        regHit, transmitBufferUnderrun, receiveBufferOverrun,
  input wire logic [5:0]  regAddr,
  input wire logic [7:0]  regRdata, pllCalSetting,
  input wire logic [4:0]  radioState,
  input wire logic [15:0] wakeTimer,
  input wire logic [6:0]  transmitByteCount, receiveByteCount, rcCalResultOne
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  wire stRd  = regRead && regAddr == 6'h38;
  wire mapRd = regRead && regAddr inside {[6'h35:6'h3d]};
  read_hit_a: assert property (regRead |=>
    regHit == $past(mapRd)) else $error("hit flag wrong");
  unmapped_zero_a: assert property (regRead && !mapRd |=>
    regRdata == 8'h00) else $error("unmapped read not zero");
  write_ignored_a: assert property (regWrite && !regRead |=>
    $stable(regRdata) && !regRvalid) else $error("write had an effect");
  state_code_a: assert property (regRead && regAddr == 6'h35 |=>
    regRdata == {3'b000, $past(radioState)}) else $error("state read wrong");
  timer_bytes_a: assert property (regRead &&
    regAddr[5:1] == 5'h1b |=>
    regRdata == ($past(regAddr[0]) ? $past(wakeTimer[7:0])
      : $past(wakeTimer[15:8]))) else $error("timer byte wrong");
  pll_setting_a: assert property (regRead && regAddr == 6'h39 |=>
    regRdata == $past(pllCalSetting)) else $error("pll setting wrong");
  fifo_levels_a: assert property (regRead &&
    regAddr[5:1] == 5'h1d |=>
    regRdata == ($past(regAddr[0])
      ? {$past(receiveBufferOverrun), $past(receiveByteCount)}
      : {$past(transmitBufferUnderrun), $past(transmitByteCount)}))
    else $error("fifo level wrong");
  rc_result_a: assert property (regRead && regAddr == 6'h3c |=>
    regRdata == {1'b0, $past(rcCalResultOne)}) else $error("rc result wrong");
  frame_tx_zero_a: assert property (stRd &&
    radioState inside {5'h13, 5'h14} |=> !regRdata[3])
    else $error("frame start set in transmit");
  unused_bit_a: assert property (stRd |=> !regRdata[1])
    else $error("unused status bit set");
  rc_high_zero_a: assert property (regRead &&
    regAddr inside {6'h3c, 6'h3d} |=> !regRdata[7])
    else $error("rc result bit 7 set");
  carrier_idle_a: assert property (stRd && $past(radioState) == 5'h01
    |=> !regRdata[6]) else $error("carrier set in idle");
endmodule

/* tb/host_model.sv */
// host side model: one register access per cycle on the strobe bus
// assumes the bench calls access just after each rising edge
`timescale 1ns/100ps
module host_model (
  output logic       regRead,
  output logic       regWrite,
  output logic [5:0] regAddr,
  output logic [7:0] regWdata
);
  initial begin
    {regRead, regWrite, regAddr, regWdata} = '0;
  end
  task automatic access(input logic rd, input logic wr,
                        input logic [5:0] a, input logic [7:0] d);
    regRead  = rd;
    regWrite = wr;
    regAddr  = a;
    regWdata = d;
  endtask
endmodule

/* tb/tb_top.sv */
// random bench for the radio status bank against a behavioural model
// assumes one clock; the host model issues all register accesses
`timescale 1ns/100ps
module tb_top;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        regRead, regWrite, regRvalid, regHit;
  logic [5:0]  regAddr;
  logic [7:0]  regWdata, regRdata, pllCalSetting;
  logic [7:0]  preambleQualityLevel, preambleQualityThreshold;
  logic [4:0]  radioState;
  logic [15:0] wakeTimer;
  logic        crcDone, crcMatch, carrierSense, channelClear, syncFound;
  logic        packetEnd, packetDiscard, pinTwoLevel, pinZeroLevel;
  logic        transmitBufferUnderrun, receiveBufferOverrun;
  logic [6:0]  transmitByteCount, receiveByteCount;
  logic [6:0]  rcCalResultOne, rcCalResultZero;
  logic        crc, cs, pq, fs, prevRx;
  logic [1:0]  s1, s2;
  logic [8:0]  q[$];
  logic [8:0]  e;
  logic [31:0] r, r3, r4;
  logic [31:0] rng = 32'h0000_3ea8;
  logic [4:0]  sts[8] = '{5'h01, 5'h0d, 5'h0e, 5'h0f,
                          5'h11, 5'h13, 5'h14, 5'h08};
  int          errors = 0;
  int          testsRun = 0;
  wire         isRx = radioState inside {5'h0d, 5'h0e, 5'h0f};

  radio_status_register_bank i_radio_status_register_bank (.clk_sys, .srst,
    .regRead, .regWrite, .regAddr, .regWdata, .regRdata, .regRvalid, .regHit,
    .radioState, .wakeTimer, .crcDone, .crcMatch, .carrierSense,
    .preambleQualityLevel, .preambleQualityThreshold, .channelClear,
    .syncFound, .packetEnd, .packetDiscard, .pinTwoLevel, .pinZeroLevel,
    .pllCalSetting, .transmitByteCount, .transmitBufferUnderrun,
    .receiveByteCount, .receiveBufferOverrun, .rcCalResultOne,
    .rcCalResultZero);
  host_model i_host_model (.regRead, .regWrite, .regAddr, .regWdata);

  function automatic logic [31:0] nxt();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  function automatic logic [8:0] expOf(input logic [5:0] a);
    case (a)
      6'h35: return {4'h8, radioState};
      6'h36: return {1'b1, wakeTimer[15:8]};
      6'h37: return {1'b1, wakeTimer[7:0]};
      6'h38: return {1'b1, crc, cs, pq, channelClear,
        fs && !(radioState inside {5'h13, 5'h14}), s2[1], 1'b0, s2[0]};
      6'h39: return {1'b1, pllCalSetting};
      6'h3a: return {1'b1, transmitBufferUnderrun, transmitByteCount};
      6'h3b: return {1'b1, receiveBufferOverrun, receiveByteCount};
      6'h3c: return {2'b10, rcCalResultOne};
      6'h3d: return {2'b10, rcCalResultZero};
      default: return 9'h000;
    endcase
  endfunction

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (errors == 0 && testsRun > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // flag model updated on the same edge as the design's flag registers
  always @(posedge clk_sys) begin
    if (srst) begin
      {crc, cs, pq, fs, prevRx, s1, s2} <= '0;
      q.delete();
    end else begin
      if (regRead) q.push_back(expOf(regAddr));
      prevRx <= isRx;
      s1 <= {pinTwoLevel, pinZeroLevel};
      s2 <= s1;
      if (crcDone) crc <= crcMatch;
      else if ((isRx && !prevRx) || radioState == 5'h0f) crc <= 1'b0;
      cs <= carrierSense && radioState != 5'h01;
      if (preambleQualityLevel < preambleQualityThreshold) pq <= 1'b0;
      else if (isRx) pq <= 1'b1;
      if (radioState inside {5'h13, 5'h14}) fs <= 1'b0;
      else if (syncFound && isRx) fs <= 1'b1;
      else if (packetEnd || packetDiscard || radioState == 5'h11)
        fs <= 1'b0;
    end
  end

  always @(negedge clk_sys) begin
    if (regRvalid !== 1'b0) begin
      e = (q.size() > 0) ? q.pop_front() : 9'h1ff;
      check({regHit, regRdata}, e);
    end
  end

  initial forever #5 clk_sys = ~clk_sys;

  initial begin
    #100000;
    errors++;
    summarize();
  end

  initial begin
    {crcDone, crcMatch, carrierSense, channelClear, syncFound} = '0;
    {packetEnd, packetDiscard, pinTwoLevel, pinZeroLevel} = '0;
    {radioState, wakeTimer, pllCalSetting, rcCalResultOne} = '0;
    {preambleQualityLevel, preambleQualityThreshold, rcCalResultZero} = '0;
    {transmitBufferUnderrun, transmitByteCount} = '0;
    {receiveBufferOverrun, receiveByteCount} = '0;
    repeat (10) @(posedge clk_sys);
    for (int i = 0; i < 3000; i++) begin
      #1;
      r  = nxt();
      r3 = nxt();
      r4 = nxt();
      srst = (i >= 1500 && i < 1503);
      if (r[23:21] == 3'b000) radioState = sts[r[26:24]];
      {wakeTimer, pllCalSetting} = r3[23:0];
      {preambleQualityLevel, preambleQualityThreshold} = r4[15:0];
      {transmitBufferUnderrun, transmitByteCount} = r3[31:24];
      {receiveBufferOverrun, receiveByteCount} = r4[23:16];
      {rcCalResultOne, rcCalResultZero} = {r4[30:24], r3[6:0]};
      {crcDone, crcMatch, carrierSense, channelClear} = {&r[7:6], r[10:8]};
      syncFound = &r[12:11];
      {packetEnd, packetDiscard} = {&r[15:13], &r[18:16]};
      {pinTwoLevel, pinZeroLevel} = r[20:19];
      i_host_model.access(r[0] && !(i >= 1499 && i < 1504), r[1],
                          {2'b11, r[5:2]}, r4[31:24]);
      @(posedge clk_sys);
    end
    repeat (3) @(posedge clk_sys);
    summarize();
  end
endmodule

bind radio_status_register_bank radio_status_props i_radio_status_props (
  .clk_sys, .srst, .regRead, .regWrite, .regRvalid, .regHit, .regAddr,
  .regRdata, .pllCalSetting, .radioState, .wakeTimer, .transmitByteCount,
  .receiveByteCount, .rcCalResultOne, .transmitBufferUnderrun,
  .receiveBufferOverrun);
